// ==== rtl/mlc_codec.v ====
`timescale 1ns/100ps
`include "mlc_defines.vh"
module mlc_codec #(
   parameter [2:0] T_LINEPAR = `MLC_DEF_T_LINEPAR,
   parameter [2:0] T_DTR = `MLC_DEF_T_DTR,
   parameter [2:0] T_BREAK = `MLC_DEF_T_BREAK,
   parameter NPORT = 8
) (
   input wire mclk,
   input wire nrst,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output wire [31:0] rdata,
   input wire rx_ui_valid,
   input wire [15:0] rx_ui_word,
   input wire psf_valid,
   input wire [15:0] psf_word,
   input wire reset_request_frame,
   output reg self_reset,
   output reg aux_reset_request,
   input wire loopback_frame_valid,
   input wire [7:0] loopback_frame_byte,
   input wire loopback_frame_last,
   output reg lb_out_valid,
   output reg [7:0] lb_out_byte,
   output reg lb_out_last,
   input wire info_valid,
   input wire [7:0] info_byte,
   input wire info_last,
   output reg info_ready,
   output reg chr_valid,
   output reg [2:0] chr_port,
   output reg [7:0] chr_data,
   input wire chr_ready,
   input wire rt_link_up,
   input wire rt_frame_buf,
   input wire rt_frame_sent,
   output reg tx_ui_valid,
   output reg [15:0] tx_ui_word,
   input wire tx_ui_ready,
   output reg cfg_valid,
   output reg [2:0] cfg_port,
   output reg [12:0] cfg_word,
   output reg [NPORT-1:0] port_break,
   output reg [NPORT-1:0] port_rx_en,
   output reg [NPORT-1:0] port_dtr
);
   // Sub-field decoder states
   localparam [2:0] SF_HDR = 3'b001;
   localparam [2:0] SF_DATA = 3'b010;
   localparam [2:0] SF_SPC = 3'b100;
   // Route-through announcement states
   localparam [1:0] RT_ON = 2'b01;
   localparam [1:0] RT_OFF = 2'b10;

   // Builds a remote-to-local message word from type and body
   function [15:0] mlc_msg;
      input [2:0] typ;
      input [12:0] body;
      begin
         mlc_msg = {typ, body};
      end
   endfunction

   // Reset-request frame acts as a power-up reset, but only nrst clears the table read port
   wire init = !nrst || reset_request_frame;

   reg [1:0] ctrl_reg;
   reg boot_reg;
   reg [2:0] sf_state_reg;
   reg [2:0] sf_state_next;
   reg [3:0] sf_cnt_reg;
   reg [3:0] sf_cnt_next;
   reg [2:0] sf_port_reg;
   reg [2:0] sf_port_next;
   reg chr_valid_next;
   reg [7:0] chr_data_next;
   reg [1:0] rt_state_reg;
   reg [7:0] rt_cnt_reg;
   reg sw_pend_reg;
   reg [15:0] sw_word_reg;

   wire [2:0] ui_type = rx_ui_word[`MLC_TYPE_HI:`MLC_TYPE_LO];
   wire [2:0] ui_port = rx_ui_word[`MLC_PORT_HI:0];
   wire ui_linepar = rx_ui_valid && (ui_type == T_LINEPAR);
   wire [2:0] psf_port = psf_word[`MLC_PORT_HI:0];

   // Power-up sequence: one reset request toward the next multiplexer
   always @(posedge mclk) begin
      self_reset <= reset_request_frame;
      if (init) begin
         boot_reg <= 1'b1;
         aux_reset_request <= 1'b0;
      end else begin
         boot_reg <= 1'b0;
         aux_reset_request <= boot_reg;
      end
   end

   // Line parameters and port setup both land in the port table
   wire tab_we = ui_linepar || psf_valid;
   wire [2:0] tab_waddr = psf_valid ? psf_port : ui_port;
   wire [15:0] tab_wdata = psf_valid ? psf_word : rx_ui_word;
   // Setup frame also writes the mapped line number; parameter message
   // must leave it alone
   wire [15:0] tab_wmask = psf_valid ? `MLC_FULL_MASK : `MLC_PARAM_MASK;

   // Reception enable per port from bit 12 of either message
   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_rxen
         always @(posedge mclk) begin
            if (init) begin
               port_rx_en[gi] <= 1'b0;
            end else if (psf_valid && psf_port == gi) begin
               port_rx_en[gi] <= psf_word[`MLC_RXEN_BIT];
            end else if (ui_linepar && ui_port == gi) begin
               port_rx_en[gi] <= rx_ui_word[`MLC_RXEN_BIT];
            end
         end
      end
   endgenerate

   // Received control messages: parameters, break, terminal ready
   always @(posedge mclk) begin
      if (init) begin
         cfg_valid <= 1'b0;
         cfg_port <= 3'h0;
         cfg_word <= 13'h0000;
         port_break <= {NPORT{1'b0}};
         port_dtr <= {NPORT{1'b0}};
      end else begin
         cfg_valid <= ui_linepar;
         if (ui_linepar) begin
            cfg_port <= ui_port;
            cfg_word <= rx_ui_word[`MLC_PARAM_HI:0];
         end
         // Bits 8 to 12 carry nothing for break
         if (rx_ui_valid && ui_type == T_BREAK) begin
            port_break <= rx_ui_word[NPORT-1:0];
         end
         if (rx_ui_valid && ui_type == T_DTR) begin
            port_dtr <= rx_ui_word[NPORT-1:0];
         end
      end
   end

   // Loopback echo; frames pass with a single register of delay
   always @(posedge mclk) begin
      if (init) begin
         lb_out_valid <= 1'b0;
         lb_out_byte <= 8'h00;
         lb_out_last <= 1'b0;
      end else begin
         lb_out_valid <= loopback_frame_valid && ctrl_reg[`MLC_CTRL_LBEN];
         lb_out_byte <= loopback_frame_byte;
         lb_out_last <= loopback_frame_last;
      end
   end

   // Sub-field decoder; accepts a byte only when the char slot is empty,
   // trading half throughput for a registered ready
   wire info_take = info_valid && info_ready;
   wire slot_free = !chr_valid || chr_ready;
   always @* begin
      sf_state_next = sf_state_reg;
      sf_cnt_next = sf_cnt_reg;
      sf_port_next = sf_port_reg;
      chr_valid_next = chr_valid && !chr_ready;
      chr_data_next = chr_data;
      case (sf_state_reg)
         SF_HDR: begin
            if (info_take) begin
               sf_port_next = info_byte[`MLC_HDR_PORT_HI:`MLC_HDR_PORT_LO];
               sf_cnt_next = info_byte[`MLC_HDR_CNT_HI:0];
               if (info_byte[`MLC_HDR_SPC]) begin
                  sf_state_next = SF_SPC;
               end else if (!info_last) begin
                  sf_state_next = SF_DATA;
               end
            end
         end
         SF_DATA: begin
            if (info_take) begin
               chr_valid_next = 1'b1;
               chr_data_next = info_byte;
               sf_cnt_next = sf_cnt_reg - 4'h1;
               // Count exhausted or field ended: next byte is a header
               if (sf_cnt_reg == 4'h0 || info_last) begin
                  sf_state_next = SF_HDR;
               end
            end
         end
         SF_SPC: begin
            if (slot_free) begin
               chr_valid_next = 1'b1;
               chr_data_next = `MLC_SPACE_CHAR;
               sf_cnt_next = sf_cnt_reg - 4'h1;
               if (sf_cnt_reg == 4'h0) begin
                  sf_state_next = SF_HDR;
               end
            end
         end
         default: begin
            sf_state_next = SF_HDR;
         end
      endcase
   end

   // Decoder registers and its output slot
   always @(posedge mclk) begin
      if (init) begin
         sf_state_reg <= SF_HDR;
         sf_cnt_reg <= 4'h0;
         sf_port_reg <= 3'h0;
         chr_valid <= 1'b0;
         chr_data <= 8'h00;
         chr_port <= 3'h0;
         info_ready <= 1'b0;
      end else begin
         sf_state_reg <= sf_state_next;
         sf_cnt_reg <= sf_cnt_next;
         sf_port_reg <= sf_port_next;
         chr_valid <= chr_valid_next;
         chr_data <= chr_data_next;
         if (chr_valid_next && !chr_valid) begin
            chr_port <= sf_port_next;
         end else if (slot_free) begin
            chr_port <= sf_port_next;
         end
         info_ready <= (sf_state_next != SF_SPC) && !chr_valid_next;
      end
   end

   // Frames held for the far multiplexer, counted whether its link is up or down
   wire rt_want_off = !rt_link_up && (rt_cnt_reg > `MLC_RT_LIMIT);
   wire tx_free = !tx_ui_valid || tx_ui_ready;
   wire rt_send_off = (rt_state_reg == RT_ON) && rt_want_off &&
      ctrl_reg[`MLC_CTRL_RTAUTO];
   wire rt_send_on = (rt_state_reg == RT_OFF) && rt_link_up;
   always @(posedge mclk) begin
      if (init) begin
         rt_cnt_reg <= 8'h00;
         rt_state_reg <= RT_ON;
      end else begin
         if (rt_frame_buf && !rt_frame_sent && rt_cnt_reg != 8'hff) begin
            rt_cnt_reg <= rt_cnt_reg + 8'h01;
         end else if (rt_frame_sent && !rt_frame_buf &&
                      rt_cnt_reg != 8'h00) begin
            rt_cnt_reg <= rt_cnt_reg - 8'h01;
         end
         case (rt_state_reg)
            RT_ON: begin
               if (rt_send_off && tx_free) begin
                  rt_state_reg <= RT_OFF;
               end
            end
            RT_OFF: begin
               if (rt_send_on && tx_free) begin
                  rt_state_reg <= RT_ON;
               end
            end
            default: begin
               rt_state_reg <= RT_ON;
            end
         endcase
      end
   end

   // Software-queued message; a write while one waits is dropped,
   // so software polls the busy bit first
   wire a_flow = wr && addr == `MLC_A_FLOW;
   wire a_carr = wr && addr == `MLC_A_CARR;
   wire a_ring = wr && addr == `MLC_A_RING;
   wire sw_take = tx_free && !rt_send_off && !rt_send_on;
   always @(posedge mclk) begin
      if (init) begin
         ctrl_reg <= `MLC_CTRL_RST;
         sw_pend_reg <= 1'b0;
         sw_word_reg <= 16'h0000;
      end else begin
         if (wr && addr == `MLC_A_CTRL) begin
            ctrl_reg <= wdata[1:0];
         end
         if (sw_pend_reg) begin
            sw_pend_reg <= !sw_take;
         end else if (a_flow) begin
            sw_pend_reg <= 1'b1;
            sw_word_reg <= mlc_msg(wdata[`MLC_FLOW_DIS] ? `MLC_T_TXDIS :
               `MLC_T_TXEN, {10'h000, wdata[`MLC_PORT_HI:0]});
         end else if (a_carr) begin
            sw_pend_reg <= 1'b1;
            sw_word_reg <= mlc_msg(`MLC_T_CARRIER,
               {5'h00, wdata[`MLC_MAP_HI:0]});
         end else if (a_ring) begin
            sw_pend_reg <= 1'b1;
            sw_word_reg <= mlc_msg(`MLC_T_RING,
               {5'h00, wdata[`MLC_MAP_HI:0]});
         end
      end
   end

   // Outgoing message slot; route-through news goes ahead of software
   always @(posedge mclk) begin
      if (init) begin
         tx_ui_valid <= 1'b0;
         tx_ui_word <= 16'h0000;
      end else if (tx_free) begin
         if (rt_send_off) begin
            tx_ui_valid <= 1'b1;
            tx_ui_word <= mlc_msg(`MLC_T_RTDIS, 13'h0000);
         end else if (rt_send_on) begin
            tx_ui_valid <= 1'b1;
            tx_ui_word <= mlc_msg(`MLC_T_RTEN, 13'h0000);
         end else begin
            tx_ui_valid <= sw_pend_reg;
            tx_ui_word <= sw_word_reg;
         end
      end
   end

   // Register read data; the table read register is the output flop
   reg [31:0] rd_mux;
   always @* begin
      case (addr)
         `MLC_A_CTRL: rd_mux = {30'h0, ctrl_reg};
         `MLC_A_STAT: rd_mux = {20'h00000, rt_cnt_reg, 1'b0, sw_pend_reg,
            rt_link_up, rt_state_reg == RT_OFF};
         `MLC_A_BRK: rd_mux = {{(32-NPORT){1'b0}}, port_break};
         `MLC_A_DTR: rd_mux = {{(32-NPORT){1'b0}}, port_dtr};
         default: rd_mux = 32'h00000000;
      endcase
   end

   mlc_ptab #(
      .AW(3),
      .DW(16)
   ) u_ptab (
      .clk(mclk),
      .we(tab_we),
      .waddr(tab_waddr),
      .wdata(tab_wdata),
      .wmask(tab_wmask),
      .re(rd && nrst),
      .raddr(addr[4:2]),
      .ext_sel(!addr[`MLC_A_TBL_BIT]),
      .ext_data(rd_mux),
      .rdata(rdata)
   );
endmodule

// ==== rtl/mlc_defines.vh ====
`ifndef MLC_DEFINES_VH
`define MLC_DEFINES_VH

// Control message layout, 16-bit information field
`define MLC_TYPE_HI 15
`define MLC_TYPE_LO 13
`define MLC_PORT_HI 2
`define MLC_PARAM_HI 12
`define MLC_RXEN_BIT 12
`define MLC_MAP_HI 7
`define MLC_PARAM_MASK 16'h1fff
`define MLC_FULL_MASK 16'hffff

// Remote to local message types
`define MLC_T_CARRIER 3'h1
`define MLC_T_TXEN 3'h2
`define MLC_T_TXDIS 3'h3
`define MLC_T_RTDIS 3'h5
`define MLC_T_RTEN 3'h6
`define MLC_T_RING 3'h7

// Local to remote message types, defaults of module parameters
`define MLC_DEF_T_LINEPAR 3'h4
`define MLC_DEF_T_DTR 3'h3
`define MLC_DEF_T_BREAK 3'h5

// Sub-field header byte: flag, port, count minus one
`define MLC_HDR_SPC 7
`define MLC_HDR_PORT_HI 6
`define MLC_HDR_PORT_LO 4
`define MLC_HDR_CNT_HI 3
`define MLC_SPACE_CHAR 8'h20

// Route-through buffered frame limit
`define MLC_RT_LIMIT 8'h0a

// Register offsets
`define MLC_A_CTRL 8'h00
`define MLC_A_STAT 8'h04
`define MLC_A_BRK 8'h08
`define MLC_A_FLOW 8'h0c
`define MLC_A_CARR 8'h10
`define MLC_A_RING 8'h14
`define MLC_A_DTR 8'h18
`define MLC_A_TBL_BIT 6
`define MLC_CTRL_RST 2'h3
`define MLC_CTRL_RTAUTO 0
`define MLC_CTRL_LBEN 1
`define MLC_FLOW_DIS 3

`endif

// ==== rtl/mlc_ptab.v ====
`timescale 1ns/100ps
// Per-port parameter table with a registered read port; the read
// register can also load a word from outside so that one flop
// feeds the register bus read data.
module mlc_ptab #(
   parameter AW = 3,
   parameter DW = 16
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [DW-1:0] wmask,
   input wire re,
   input wire [AW-1:0] raddr,
   input wire ext_sel,
   input wire [31:0] ext_data,
   output reg [31:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Masked write keeps fields of the entry not named by the mask
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
      end
   end

   // Read data stand only in the cycle after the read strobe
   always @(posedge clk) begin
      if (!re) begin
         rdata <= 32'h00000000;
      end else if (ext_sel) begin
         rdata <= ext_data;
      end else begin
         rdata <= {{(32-DW){1'b0}}, mem[raddr]};
      end
   end
endmodule

// ==== tb/mlc_codec_properties.sv ====
`timescale 1ns/100ps
`include "mlc_defines.vh"
// Port-level checks of the message codec
module mlc_codec_properties #(
   parameter [2:0] T_LINEPAR = `MLC_DEF_T_LINEPAR,
   parameter [2:0] T_DTR = `MLC_DEF_T_DTR,
   parameter [2:0] T_BREAK = `MLC_DEF_T_BREAK,
   parameter NPORT = 8
) (
   input wire mclk,
   input wire nrst,
   input wire rx_ui_valid,
   input wire [15:0] rx_ui_word,
   input wire reset_request_frame,
   input wire self_reset,
   input wire aux_reset_request,
   input wire loopback_frame_valid,
   input wire [7:0] loopback_frame_byte,
   input wire loopback_frame_last,
   input wire lb_out_valid,
   input wire [7:0] lb_out_byte,
   input wire lb_out_last,
   input wire chr_valid,
   input wire [2:0] chr_port,
   input wire [7:0] chr_data,
   input wire chr_ready,
   input wire rt_link_up,
   input wire rt_frame_buf,
   input wire rt_frame_sent,
   input wire tx_ui_valid,
   input wire [15:0] tx_ui_word,
   input wire tx_ui_ready,
   input wire cfg_valid,
   input wire [2:0] cfg_port,
   input wire [12:0] cfg_word,
   input wire [NPORT-1:0] port_break,
   input wire [NPORT-1:0] port_rx_en,
   input wire [NPORT-1:0] port_dtr
);
   wire [2:0] rx_type = rx_ui_word[15:13];
   reg [7:0] held_reg;
   // Own copy of the held-frame count, saturating like the design's
   always @(posedge mclk) begin
      if (!nrst || reset_request_frame)
         held_reg <= 8'h00;
      else if (rt_frame_buf && !rt_frame_sent && held_reg != 8'hff)
         held_reg <= held_reg + 8'h01;
      else if (rt_frame_sent && !rt_frame_buf && held_reg != 8'h00)
         held_reg <= held_reg - 8'h01;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_boot;
      aux_reset_request ##1 !aux_reset_request;
   endsequence
   sequence s_over;
      $rose(held_reg > 8'h0a) && !rt_link_up && !tx_ui_valid;
   endsequence
   property p_cfg;
      rx_ui_valid && rx_type == T_LINEPAR |=> cfg_valid &&
         cfg_port == $past(rx_ui_word[2:0]) &&
         cfg_word == $past(rx_ui_word[12:0]);
   endproperty
   a_cfg: assert property (p_cfg) else $error("params not applied");
   property p_rxen;
      cfg_valid |-> port_rx_en[cfg_port] == cfg_word[12];
   endproperty
   a_rxen: assert property (p_rxen) else $error("rx enable wrong");
   property p_brk;
      rx_ui_valid && rx_type == T_BREAK |=>
         port_break == $past(rx_ui_word[7:0]);
   endproperty
   a_brk: assert property (p_brk) else $error("break map wrong");
   property p_dtr;
      rx_ui_valid && rx_type == T_DTR |=> port_dtr == $past(rx_ui_word[7:0]);
   endproperty
   a_dtr: assert property (p_dtr) else $error("ready map wrong");
   property p_self;
      reset_request_frame |=> self_reset;
   endproperty
   a_self: assert property (p_self) else $error("no self reset");
   property p_aux;
      $rose(nrst) |-> ##[1:2] s_boot;
   endproperty
   a_aux: assert property (p_aux) else $error("no aux request");
   property p_lb;
      loopback_frame_valid |=> lb_out_valid &&
         lb_out_last == $past(loopback_frame_last) &&
         lb_out_byte == $past(loopback_frame_byte);
   endproperty
   a_lb: assert property (p_lb) else $error("loopback differs");
   property p_hold;
      tx_ui_valid && !tx_ui_ready |=> tx_ui_valid && $stable(tx_ui_word);
   endproperty
   a_hold: assert property (p_hold) else $error("message dropped");
   property p_type;
      tx_ui_valid |-> tx_ui_word[15:13] != 3'h0 && tx_ui_word[15:13] != 3'h4;
   endproperty
   a_type: assert property (p_type) else $error("bad message type");
   property p_chr;
      chr_valid && !chr_ready |=> chr_valid && $stable({chr_port, chr_data});
   endproperty
   a_chr: assert property (p_chr) else $error("char not held");
   property p_rtdis;
      s_over |-> ##[0:3] (tx_ui_valid && tx_ui_word == 16'ha000);
   endproperty
   a_rtdis: assert property (p_rtdis) else $error("no route disable");
endmodule
bind mlc_codec mlc_codec_properties #(.T_LINEPAR(T_LINEPAR), .T_DTR(T_DTR),
   .T_BREAK(T_BREAK), .NPORT(NPORT)) i_props (.*);

// ==== tb/mlc_far_mux.sv ====
`timescale 1ns/100ps
// Far multiplexer: takes outgoing messages, sends incoming ones
module mlc_far_mux (
   input wire mclk,
   input wire nrst,
   input wire slow,
   input wire tx_ui_valid,
   input wire [15:0] tx_ui_word,
   output reg tx_ui_ready,
   output reg rx_ui_valid,
   output reg [15:0] rx_ui_word,
   output reg [15:0] last_word,
   output reg [7:0] n_got,
   output reg [7:0] stop_mask,
   output reg far_blocked
);
   reg [1:0] ph_reg;
   initial begin
      rx_ui_valid = 1'b0;
      rx_ui_word = 16'h0000;
      tx_ui_ready = 1'b1;
      ph_reg = 2'h0;
   end
   // Slow mode takes one slot in four, so the sender must hold its word
   always @(posedge mclk) begin
      ph_reg <= ph_reg + 2'h1;
      tx_ui_ready <= !slow || ph_reg == 2'h3;
      if (!nrst) begin
         n_got <= 8'h00;
         stop_mask <= 8'h00;
         far_blocked <= 1'b0;
         last_word <= 16'h0000;
      end else if (tx_ui_valid && tx_ui_ready) begin
         last_word <= tx_ui_word;
         n_got <= n_got + 8'h01;
         case (tx_ui_word[15:13])
            3'h3: stop_mask[tx_ui_word[2:0]] <= 1'b1;
            3'h2: stop_mask[tx_ui_word[2:0]] <= 1'b0;
            3'h5: far_blocked <= 1'b1;
            3'h6: far_blocked <= 1'b0;
            default: ;
         endcase
      end
   end
   // One message; the line shows the inverse once released
   task send(input [15:0] w);
      rx_ui_valid <= 1'b1;
      rx_ui_word <= w;
      @(posedge mclk);
      rx_ui_valid <= 1'b0;
      rx_ui_word <= ~w;
      @(posedge mclk);
   endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`include "mlc_defines.vh"
module tb;
   reg mclk, nrst, wr, rd, psf_valid, reset_request_frame, slow;
   reg loopback_frame_valid, loopback_frame_last, info_valid, info_last;
   reg chr_ready, rt_link_up, rt_frame_buf, rt_frame_sent;
   reg [7:0] addr, loopback_frame_byte, info_byte;
   reg [31:0] wdata, seed, r, d;
   reg [15:0] psf_word, w, v;
   wire [31:0] rdata;
   wire self_reset, aux_reset_request, lb_out_valid, lb_out_last;
   wire info_ready, chr_valid, tx_ui_valid, tx_ui_ready, cfg_valid;
   wire rx_ui_valid, far_blocked;
   wire [7:0] lb_out_byte, chr_data, port_break, port_rx_en, port_dtr;
   wire [7:0] n_got, stop_mask;
   wire [2:0] chr_port, cfg_port;
   wire [12:0] cfg_word;
   wire [15:0] tx_ui_word, rx_ui_word, last_word;
   integer miscompares, checks_done, cyc, i, n, p;
   reg [10:0] got[$];
   reg [10:0] exp[$];
   mlc_codec i_dut (.*);
   mlc_far_mux i_far (.*);
   always #12.5 mclk = ~mclk;
   function [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
   endfunction
   task print_verdict;
      if (miscompares == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input [31:0] gv, input [31:0] ev);
      checks_done = checks_done + 1;
      if (gv !== ev) begin
         miscompares = miscompares + 1;
         $display("ERROR %0t got %h expected %h", $time, gv, ev);
      end
   endtask
   // Bus strobes drop for a cycle, so back-to-back calls never clash
   task wr_reg(input [7:0] a, input [31:0] dv);
      addr <= a;
      wdata <= dv;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task rd_reg(input [7:0] a, output [31:0] dv);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 dv = rdata;
      @(posedge mclk);
   endtask
   task flow(input [7:0] a, input [31:0] dv, input [15:0] ev);
      p = n_got;
      wr_reg(a, dv);
      for (n = 0; n < 100 && n_got == p; n = n + 1) @(posedge mclk);
      chk(last_word, ev);
   endtask
   task send_info(input [7:0] b, input l);
      info_valid <= 1'b1;
      info_byte <= b;
      info_last <= l;
      @(posedge mclk);
      for (n = 0; n < 50 && info_ready !== 1'b1; n = n + 1) @(posedge mclk);
      info_valid <= 1'b0;
      info_byte <= ~b;
      @(posedge mclk);
   endtask
   // Expected characters are queued as the sub-field is sent
   task info_sub(input [2:0] pp, input [4:0] cnt, input s, input l);
      integer k;
      send_info({s, pp, cnt[3:0] - 4'h1}, l && s);
      for (k = 0; k < cnt; k = k + 1) begin
         if (s) begin
            exp.push_back({pp, 8'h20});
         end else begin
            r = rnd();
            send_info(r[7:0], l && k == cnt - 1);
            exp.push_back({pp, r[7:0]});
         end
      end
   endtask
   // Collect characters under a random stall; time out a hang
   always @(posedge mclk) begin
      if (chr_valid === 1'b1 && chr_ready) got.push_back({chr_port, chr_data});
      chr_ready <= ^rnd();
      cyc = cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         print_verdict();
      end
   end
   initial begin
      {mclk, nrst, wr, rd, psf_valid, reset_request_frame, slow} = 7'h00;
      {loopback_frame_valid, loopback_frame_last} = 2'h0;
      {info_valid, info_last} = 2'h0;
      {chr_ready, rt_frame_buf, rt_frame_sent} = 3'h0;
      rt_link_up = 1'b1;
      {addr, loopback_frame_byte, info_byte, psf_word} = 40'h0;
      wdata = 32'h0;
      seed = 32'h4c;
      {miscompares, checks_done, cyc} = 96'h0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      rd_reg(`MLC_A_CTRL, d);
      chk(d, 32'h3);
      rd_reg(8'h20, d);
      chk(d, 32'h0);
      for (p = 0; p < 8; p = p + 1) begin
         r = rnd();
         w = {r[15:3], p[2:0]};
         v = {`MLC_DEF_T_LINEPAR, r[28:19], p[2:0]};
         psf_valid <= 1'b1;
         psf_word <= w;
         @(posedge mclk);
         psf_valid <= 1'b0;
         psf_word <= ~w;
         i_far.send(v);
         rd_reg({3'h2, p[2:0], 2'h0}, d);
         chk(d, {16'h0, w[15:13], v[12:0]});
         chk(port_rx_en[p], v[12]);
      end
      repeat (3) begin
         r = rnd();
         i_far.send({`MLC_DEF_T_BREAK, r[12:0]});
         rd_reg(`MLC_A_BRK, d);
         chk(d, {24'h0, r[7:0]});
         i_far.send({`MLC_DEF_T_DTR, r[28:16]});
         rd_reg(`MLC_A_DTR, d);
         chk(d, {24'h0, r[23:16]});
      end
      slow <= 1'b1;
      flow(`MLC_A_FLOW, 32'hd, 16'h6005);
      flow(`MLC_A_FLOW, 32'ha, 16'h6002);
      chk(stop_mask, 32'h24);
      flow(`MLC_A_FLOW, 32'h5, 16'h4005);
      chk(stop_mask, 32'h4);
      r = rnd();
      flow(`MLC_A_CARR, r, {8'h20, r[7:0]});
      flow(`MLC_A_RING, r, {8'he0, r[7:0]});
      slow <= 1'b0;
      rt_link_up <= 1'b0;
      for (i = 0; i < 11; i = i + 1) begin
         if (i == 10) begin
            repeat (6) @(posedge mclk);
            chk(far_blocked, 32'h0);
         end
         rt_frame_buf <= 1'b1;
         @(posedge mclk);
         rt_frame_buf <= 1'b0;
         @(posedge mclk);
      end
      for (n = 0; n < 20 && far_blocked !== 1'b1; n = n + 1) @(posedge mclk);
      chk(far_blocked, 32'h1);
      rd_reg(`MLC_A_STAT, d);
      chk(d, 32'hb1);
      rt_link_up <= 1'b1;
      repeat (3) begin
         rt_frame_sent <= 1'b1;
         @(posedge mclk);
         rt_frame_sent <= 1'b0;
         @(posedge mclk);
      end
      for (n = 0; n < 20 && far_blocked !== 1'b0; n = n + 1) @(posedge mclk);
      chk(far_blocked, 32'h0);
      rd_reg(`MLC_A_STAT, d);
      chk(d, 32'h82);
      wr_reg(`MLC_A_CTRL, 32'h2);
      reset_request_frame <= 1'b1;
      @(posedge mclk);
      reset_request_frame <= 1'b0;
      repeat (3) @(posedge mclk);
      rd_reg(`MLC_A_CTRL, d);
      chk(d, 32'h3);
      wr_reg(`MLC_A_STAT, 32'hffff);
      rd_reg(`MLC_A_STAT, d);
      chk(d, 32'h2);
      for (i = 0; i < 4; i = i + 1) begin
         r = rnd();
         loopback_frame_valid <= 1'b1;
         loopback_frame_byte <= r[7:0];
         loopback_frame_last <= i == 3;
         @(posedge mclk);
      end
      loopback_frame_valid <= 1'b0;
      loopback_frame_byte <= ~r[7:0];
      info_sub(3'h2, 5'h2, 1'b0, 1'b0);
      info_sub(3'h1, 5'h4, 1'b1, 1'b0);
      info_sub(3'h7, 5'h10, 1'b1, 1'b0);
      info_sub(3'h0, 5'h10, 1'b0, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
         r = rnd();
         info_sub(r[2:0], {1'b0, r[7:4]} + 5'h1, r[8], i == 3);
      end
      for (n = 0; n < 200 && got.size() < exp.size(); n = n + 1)
         @(posedge mclk);
      repeat (4) @(posedge mclk);
      chk(got.size(), exp.size());
      foreach (exp[i]) chk(got[i], exp[i]);
      print_verdict();
   end
endmodule
